// >>> pkg/vcpr_cfg.svh
// Purpose: constants for the virtual priority register block
// Assumes: system register encodings as decoded by the core
// Notes:   timing-free block, all figures are encodings and fields
`ifndef VCPR_CFG_SVH
`define VCPR_CFG_SVH

// Encoding fields
`define VCPR_OP0_SYS     2'h3
`define VCPR_CRN_IRQ     4'hc
`define VCPR_OP1_EL1     3'h0
`define VCPR_CRM_AP1     4'h9
`define VCPR_OP2_AP1_HI  1'h0
`define VCPR_CRM_BPR0    4'h8
`define VCPR_OP2_BPR0    3'h3

// Field layout
`define VCPR_AP_W        32
`define VCPR_BP_W        3
`define VCPR_NUM_AP      4

// Preemption bit counts, encoded as count minus one
`define VCPR_PRE_BITS_5  3'h4
`define VCPR_PRE_BITS_6  3'h5
`define VCPR_PRE_BITS_7  3'h6

// Minimum binary point per preemption bit count
`define VCPR_BP_MIN_7    3'h0
`define VCPR_BP_MIN_6    3'h1
`define VCPR_BP_MIN_5    3'h2

// Reset values (contents are architecturally unknown)
`define VCPR_AP_RST      32'h0000_0000
`define VCPR_BP_RST      3'h2

`endif

// >>> pkg/vcpr_pkg.sv
// Purpose: types for the virtual priority register block
// Assumes: included config header defines widths
// Notes:   none
`include "vcpr_cfg.svh"
package vcpr_pkg;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [1:0] op0;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
        logic [63:0] wdata;
    } vcpr_req_s;

    typedef struct packed {
        logic       nonsecure_state;
        logic       secure_second_level_enable;
        logic       irq_route_override;
        logic       fiq_route_override;
        logic       general_trap_to_hypervisor;
        logic       trap_all_group0;
        logic       trap_all_group1;
        logic       sysreg_iface_enable;
        logic       secure_access_check;
        logic [2:0] preemption_bit_count;
    } vcpr_ctl_s;

    typedef enum logic [4:0] {
        VCPR_RES_NONE     = 5'b00001,
        VCPR_RES_VIRTUAL  = 5'b00010,
        VCPR_RES_PHYSICAL = 5'b00100,
        VCPR_RES_TRAP_EL1 = 5'b01000,
        VCPR_RES_TRAP_EL2 = 5'b10000
    } vcpr_route_e;

    typedef enum logic [2:0] {
        VCPR_ANS_OK    = 3'b001,
        VCPR_ANS_UNDEF = 3'b010,
        VCPR_ANS_TRAP  = 3'b100
    } vcpr_ans_e;

endpackage

// >>> src/vcpr_bp_clamp.sv
// Purpose: minimum binary point and write clamp
// Assumes: preemption count given as count minus one
// Notes:   unknown counts fall back to the five-bit minimum
`timescale 1ns/10ps
`include "vcpr_cfg.svh"
module vcpr_bp_clamp (
    // Inputs
    input  wire logic [2:0] i_pre_bits,
    input  wire logic [2:0] i_wval,
    // Outputs
    output logic      [2:0] o_min,
    output logic      [2:0] o_store
);
    assign o_min = (i_pre_bits == `VCPR_PRE_BITS_7) ? `VCPR_BP_MIN_7 :
                   (i_pre_bits == `VCPR_PRE_BITS_6) ? `VCPR_BP_MIN_6 :
                   `VCPR_BP_MIN_5;
    assign o_store = (i_wval < o_min) ? o_min : i_wval;
endmodule // vcpr_bp_clamp

// >>> src/vcpr_regs.sv
// Purpose: virtual group 1 active priority and group 0 binary point
// Assumes: one access per cycle from the core, answered next cycle
// Notes:   physical registers live elsewhere; this block only routes
`timescale 1ns/10ps
`include "vcpr_cfg.svh"

module vcpr_regs (
    // Clock and reset
    input  wire logic                I_CLK,
    input  wire logic                I_RST,
    // Access request and controls
    input  wire vcpr_pkg::vcpr_req_s I_REQ,
    input  wire vcpr_pkg::vcpr_ctl_s I_CTL,
    // Answer
    output logic                     O_ACK,
    output vcpr_pkg::vcpr_ans_e      O_ANS,
    output logic                     O_TRAP_EL2,
    output logic                     O_TO_PHYS,
    output logic [63:0]              O_RDATA,
    // State views
    output logic                     O_G1_NONE_ACTIVE,
    output logic [2:0]               O_BP0
);
    import vcpr_pkg::*;

    logic [`VCPR_AP_W-1:0] ap_reg [`VCPR_NUM_AP];
    logic [2:0]            bp_reg;
    logic                  ack_reg;
    vcpr_ans_e             ans_reg;
    logic                  trap2_reg;
    logic                  phys_reg;
    logic [63:0]           rdata_reg;
    logic                  none_reg;
    logic [`VCPR_NUM_AP-1:0] impl;
    logic [2:0]            bp_min;
    logic [2:0]            bp_store;
    vcpr_route_e           route;

    wire base_hit = I_REQ.valid && I_REQ.op0 == `VCPR_OP0_SYS
                 && I_REQ.crn == `VCPR_CRN_IRQ
                 && I_REQ.op1 == `VCPR_OP1_EL1;
    wire is_ap1 = base_hit && I_REQ.crm == `VCPR_CRM_AP1
               && I_REQ.op2[2] == `VCPR_OP2_AP1_HI;
    wire is_bp0 = base_hit && I_REQ.crm == `VCPR_CRM_BPR0
               && I_REQ.op2 == `VCPR_OP2_BPR0;
    wire [1:0] idx = I_REQ.op2[1:0];

    // Register count follows the priority bit count
    assign impl[0] = 1'b1;
    assign impl[1] = I_CTL.preemption_bit_count
                     >= `VCPR_PRE_BITS_6;
    assign impl[2] = I_CTL.preemption_bit_count
                     >= `VCPR_PRE_BITS_7;
    assign impl[3] = impl[2];

    wire undef = is_ap1 && !impl[idx];

    vcpr_route u_route (
        .i_is_grp0 (is_bp0),
        .i_is_grp1 (is_ap1 && !undef),
        .i_ctl     (I_CTL),
        .o_route   (route)
    );

    vcpr_bp_clamp u_clamp (
        .i_pre_bits (I_CTL.preemption_bit_count),
        .i_wval     (I_REQ.wdata[2:0]),
        .o_min      (bp_min),
        .o_store    (bp_store)
    );

    wire virt   = route == VCPR_RES_VIRTUAL;
    wire wr_ap  = virt && is_ap1 && I_REQ.write;
    wire wr_bp  = virt && is_bp0 && I_REQ.write;
    // Only the low word is stored; it is the 32-bit view too
    wire [63:0] ap_rd = {32'h0000_0000, ap_reg[idx]};
    wire [63:0] bp_rd = {61'h0, bp_reg};
    wire [63:0] rd_next = (virt && !I_REQ.write)
                        ? (is_ap1 ? ap_rd : bp_rd) : 64'h0;
    wire ans_trap = route == VCPR_RES_TRAP_EL1
                 || route == VCPR_RES_TRAP_EL2;
    wire none_next = (ap_reg[0] | ap_reg[1] | ap_reg[2]
                     | ap_reg[3]) == 32'h0000_0000;

    // Software is trusted to restore order and values
    genvar g;
    generate
        for (g = 0; g < `VCPR_NUM_AP; g++) begin : g_ap
            always_ff @(posedge I_CLK or posedge I_RST) begin
                if (I_RST) begin
                    ap_reg[g] <= `VCPR_AP_RST;
                end else if (wr_ap && idx == g) begin
                    ap_reg[g] <= I_REQ.wdata[31:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            bp_reg <= `VCPR_BP_RST;
        end else if (wr_bp) begin
            bp_reg <= bp_store;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ack_reg   <= 1'b0;
            ans_reg   <= VCPR_ANS_OK;
            trap2_reg <= 1'b0;
            phys_reg  <= 1'b0;
            rdata_reg <= 64'h0;
            none_reg  <= 1'b1;
        end else begin
            ack_reg   <= is_ap1 || is_bp0;
            ans_reg   <= undef ? VCPR_ANS_UNDEF :
                         ans_trap ? VCPR_ANS_TRAP : VCPR_ANS_OK;
            trap2_reg <= route == VCPR_RES_TRAP_EL2;
            phys_reg  <= route == VCPR_RES_PHYSICAL;
            rdata_reg <= rd_next;
            none_reg  <= none_next;
        end
    end

    assign O_ACK            = ack_reg;
    assign O_ANS            = ans_reg;
    assign O_TRAP_EL2       = trap2_reg;
    assign O_TO_PHYS        = phys_reg;
    assign O_RDATA          = rdata_reg;
    assign O_G1_NONE_ACTIVE = none_reg;
    assign O_BP0            = bp_reg;
endmodule // vcpr_regs

// >>> src/vcpr_route.sv
// Purpose: trap and virtual/physical routing for one access
// Assumes: access already decoded to a register class
// Notes:   purely combinational
`timescale 1ns/10ps
`include "vcpr_cfg.svh"
module vcpr_route (
    // Access class
    input  wire logic                i_is_grp0,
    input  wire logic                i_is_grp1,
    // Trap and route controls
    input  wire vcpr_pkg::vcpr_ctl_s i_ctl,
    // Result
    output vcpr_pkg::vcpr_route_e    o_route
);
    import vcpr_pkg::*;

    wire sec_el2  = ~i_ctl.nonsecure_state
                  & i_ctl.secure_second_level_enable;
    wire el2_live = i_ctl.nonsecure_state
                  | i_ctl.secure_second_level_enable;
    wire tall     = (i_is_grp0 & i_ctl.trap_all_group0)
                  | (i_is_grp1 & i_ctl.trap_all_group1);
    wire trap_ns  = i_ctl.nonsecure_state & tall;
    wire trap_s   = sec_el2 & tall & i_ctl.secure_access_check;
    wire ovr      = (i_is_grp1 & i_ctl.irq_route_override)
                  | (i_is_grp0 & i_ctl.fiq_route_override);
    wire virt     = ovr & ~i_ctl.general_trap_to_hypervisor
                  & el2_live;

    // Enable trap outranks the hypervisor traps
    assign o_route = !(i_is_grp0 | i_is_grp1) ? VCPR_RES_NONE :
                     !i_ctl.sysreg_iface_enable ? VCPR_RES_TRAP_EL1 :
                     (trap_ns | trap_s) ? VCPR_RES_TRAP_EL2 :
                     virt ? VCPR_RES_VIRTUAL : VCPR_RES_PHYSICAL;
endmodule // vcpr_route

// >>> verif/vcpr_core_model.sv
// Purpose: core issuing system register accesses
// Assumes: one access, then an idle cycle
// Notes:   released data inverted so stale values never match
`timescale 1ns/10ps
module vcpr_core_model (
    // Clock
    input  wire logic           i_clk,
    // Request
    output vcpr_pkg::vcpr_req_s o_req
);
    import vcpr_pkg::*;
    initial o_req = '0;
    // Drives one request for one cycle, then drops valid and inverts the write data
    task automatic access(input logic wr, input logic [3:0] crm,
        input logic [2:0] op2, input logic [63:0] wd);
        @(negedge i_clk);
        o_req <= '{1'b1, wr, 2'h3, 3'h0, 4'hc, crm, op2, wd};
        @(negedge i_clk);
        o_req.valid <= 1'b0;
        o_req.wdata <= ~wd;
    endtask
endmodule // vcpr_core_model

// >>> verif/vcpr_regs_assertions.sv
// Purpose: port checks for the virtual priority register block
// Assumes: answer registered one cycle after a decoded access
// Notes:   bound to vcpr_regs
`timescale 1ns/10ps
module vcpr_regs_assertions (
    // Clock and reset
    input wire logic                I_CLK,
    input wire logic                I_RST,
    // Watched ports
    input wire vcpr_pkg::vcpr_req_s I_REQ,
    input wire vcpr_pkg::vcpr_ctl_s I_CTL,
    input wire logic                O_ACK,
    input wire vcpr_pkg::vcpr_ans_e O_ANS,
    input wire logic                O_TRAP_EL2,
    input wire logic                O_TO_PHYS,
    input wire logic [63:0]         O_RDATA,
    input wire logic                O_G1_NONE_ACTIVE,
    input wire logic [2:0]          O_BP0
);
    import vcpr_pkg::*;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    wire hit = I_REQ.valid && I_REQ.op0 == 2'h3 && I_REQ.crn == 4'hc
        && I_REQ.op1 == 3'h0;
    wire ap = hit && I_REQ.crm == 4'h9 && !I_REQ.op2[2];
    wire bp = hit && I_REQ.crm == 4'h8 && I_REQ.op2 == 3'h3;
    wire dec = ap || bp;
    wire [2:0] pc = I_CTL.preemption_bit_count;
    wire unimp = ap && I_REQ.op2[1:0] != 2'h0
        && (I_REQ.op2[1] ? pc < 3'h6 : pc < 3'h5);
    wire ns = I_CTL.nonsecure_state;
    wire sre = I_CTL.sysreg_iface_enable;
    wire lvl = !I_CTL.general_trap_to_hypervisor
        && (ns || I_CTL.secure_second_level_enable);
    wire [2:0] mn = pc == 3'h6 ? 3'h0 : pc == 3'h5 ? 3'h1 : 3'h2;
    wire [2:0] bx = I_REQ.wdata[2:0] < mn ? mn : I_REQ.wdata[2:0];
    wire up = ns || (I_CTL.secure_second_level_enable
        && I_CTL.secure_access_check);
    sequence s_ap_ok; ap && !unimp && sre && !(up && I_CTL.trap_all_group1);
    endsequence
    sequence s_bp_ok; bp && sre && !(up && I_CTL.trap_all_group0);
    endsequence
    sequence s_up; O_ANS == VCPR_ANS_TRAP && O_TRAP_EL2; endsequence
    property p_ack; O_ACK == $past(dec); endproperty
    property p_undef; unimp |=> O_ANS == VCPR_ANS_UNDEF; endproperty
    property p_sre; dec && !unimp && !sre |=> O_ANS == VCPR_ANS_TRAP
        && !O_TRAP_EL2; endproperty
    property p_tall; dec && !unimp && sre && (ns
        || I_CTL.secure_second_level_enable && I_CTL.secure_access_check)
        && (ap ? I_CTL.trap_all_group1 : I_CTL.trap_all_group0) |=> s_up;
    endproperty
    property p_phys; s_ap_ok ##0 !(I_CTL.irq_route_override && lvl)
        |=> O_TO_PHYS && O_RDATA == 64'h0; endproperty
    property p_virt; s_bp_ok ##0 (I_CTL.fiq_route_override && lvl)
        |=> !O_TO_PHYS && O_ANS == VCPR_ANS_OK; endproperty
    property p_clamp; s_bp_ok ##0 (I_CTL.fiq_route_override && lvl
        && I_REQ.write) |=> O_BP0 == $past(bx); endproperty
    property p_rsv; O_ACK |-> O_RDATA[63:32] == 32'h0; endproperty
    a_ack: assert property (p_ack) else $error("answer strobe wrong");
    a_undef: assert property (p_undef) else $error("missing undef");
    a_sre: assert property (p_sre) else $error("missing local trap");
    a_tall: assert property (p_tall) else $error("missing upper trap");
    a_phys: assert property (p_phys) else $error("not routed out");
    a_virt: assert property (p_virt) else $error("not virtual");
    a_clamp: assert property (p_clamp) else $error("bad clamp");
    a_rsv: assert property (p_rsv) else $error("upper word set");
endmodule // vcpr_regs_assertions
bind vcpr_regs vcpr_regs_assertions u_chk (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_REQ(I_REQ), .I_CTL(I_CTL), .O_ACK(O_ACK), .O_ANS(O_ANS),
    .O_TRAP_EL2(O_TRAP_EL2), .O_TO_PHYS(O_TO_PHYS), .O_RDATA(O_RDATA),
    .O_G1_NONE_ACTIVE(O_G1_NONE_ACTIVE), .O_BP0(O_BP0));

// >>> verif/vcpr_regs_tb.sv
// Purpose: directed test of the virtual priority register block
// Assumes: inputs change on the falling edge
// Notes:   answer checked in the cycle it stands
`timescale 1ns/10ps
module vcpr_regs_tb;
    import vcpr_pkg::*;
    logic        clk, rst, ack, el2, phys, none;
    vcpr_req_s   req;
    vcpr_ctl_s   ctl;
    vcpr_ans_e   ans;
    logic [63:0] rd;
    logic [2:0]  bp;
    int          error_cnt, comparisons;
    vcpr_core_model core (.i_clk(clk), .o_req(req));
    vcpr_regs dut (.I_CLK(clk), .I_RST(rst), .I_REQ(req), .I_CTL(ctl),
        .O_ACK(ack), .O_ANS(ans), .O_TRAP_EL2(el2), .O_TO_PHYS(phys),
        .O_RDATA(rd), .O_G1_NONE_ACTIVE(none), .O_BP0(bp));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [3:0] crm,
        input logic [2:0] op2, input logic [63:0] wd, input logic [2:0] a,
        input logic [1:0] rt);
        core.access(wr, crm, op2, wd);
        chk({ack, ans, el2, phys}, {1'b1, a, rt});
    endtask
    initial begin
        #50000;
        error_cnt++;
        final_report();
    end
    initial begin
        error_cnt = 0;
        comparisons = 0;
        rst = 1'b1;
        ctl = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h6};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int n = 0; n < 4; n++) begin
            acc(1, 4'h9, 3'(n), {32'hffff_ffff, 32'h1 << n}, 3'h1, 2'h0);
            acc(0, 4'h9, 3'(n), 64'h0, 3'h1, 2'h0);
            chk(rd, 64'h1 << n);
        end
        chk(none, 1'b0);
        for (int n = 0; n < 4; n++)
            acc(1, 4'h9, 3'(n), 64'h0, 3'h1, 2'h0);
        @(negedge clk);
        chk(none, 1'b1);
        ctl.preemption_bit_count = 3'h4;
        acc(0, 4'h9, 3'h1, 64'h0, 3'h2, 2'h0);
        ctl.preemption_bit_count = 3'h5;
        acc(1, 4'h9, 3'h2, 64'h5, 3'h2, 2'h0);
        acc(0, 4'h9, 3'h1, 64'h0, 3'h1, 2'h0);
        ctl.preemption_bit_count = 3'h6;
        acc(0, 4'h9, 3'h2, 64'h0, 3'h1, 2'h0);
        chk(rd, 64'h0);
        // Highest count first so each minimum differs from the one before
        for (int c = 6; c > 3; c--) begin
            ctl.preemption_bit_count = 3'(c);
            acc(1, 4'h8, 3'h3, 64'hffff_fff8, 3'h1, 2'h0);
            chk(bp, 3'(6 - c));
            acc(0, 4'h8, 3'h3, 64'h0, 3'h1, 2'h0);
            chk(rd, 64'(6 - c));
        end
        acc(1, 4'h8, 3'h3, 64'h7, 3'h1, 2'h0);
        chk(bp, 3'h7);
        ctl.sysreg_iface_enable = 1'b0;
        acc(0, 4'h9, 3'h0, 64'h0, 3'h4, 2'h0);
        acc(0, 4'h8, 3'h3, 64'h0, 3'h4, 2'h0);
        ctl.sysreg_iface_enable = 1'b1;
        ctl.trap_all_group1 = 1'b1;
        acc(0, 4'h9, 3'h0, 64'h0, 3'h4, 2'h2);
        acc(0, 4'h8, 3'h3, 64'h0, 3'h1, 2'h0);
        ctl.trap_all_group1 = 1'b0;
        ctl.trap_all_group0 = 1'b1;
        acc(0, 4'h8, 3'h3, 64'h0, 3'h4, 2'h2);
        acc(0, 4'h9, 3'h0, 64'h0, 3'h1, 2'h0);
        ctl.nonsecure_state = 1'b0;
        ctl.secure_second_level_enable = 1'b1;
        ctl.secure_access_check = 1'b1;
        acc(0, 4'h8, 3'h3, 64'h0, 3'h4, 2'h2);
        ctl.secure_access_check = 1'b0;
        acc(0, 4'h8, 3'h3, 64'h0, 3'h1, 2'h0);
        ctl.trap_all_group0 = 1'b0;
        ctl.irq_route_override = 1'b0;
        acc(0, 4'h9, 3'h0, 64'h0, 3'h1, 2'h1);
        chk(rd, 64'h0);
        ctl.fiq_route_override = 1'b0;
        acc(1, 4'h8, 3'h3, 64'h5, 3'h1, 2'h1);
        chk(bp, 3'h7);
        ctl.irq_route_override = 1'b1;
        ctl.general_trap_to_hypervisor = 1'b1;
        acc(0, 4'h9, 3'h0, 64'h0, 3'h1, 2'h1);
        final_report();
    end
endmodule // vcpr_regs_tb
